//--- pkg/agz_defs.vh
// constants for the converter front-end control block
`ifndef AGZ_DEFS_VH
`define AGZ_DEFS_VH
`define AGZ_ADDR_CFG0 8'h00
`define AGZ_ADDR_CFG2 8'h04
`define AGZ_ADDR_MUX 8'h08
`define AGZ_ADDR_CTRL 8'h0C
`define AGZ_ADDR_STAT 8'h10
`define AGZ_ADDR_RES 8'h14
`define AGZ_ADDR_ANA 8'h18
`define AGZ_CFG0_CS_LSB 2
`define AGZ_CFG2_GAIN_LSB 3
`define AGZ_CFG2_AZ_BIT 2
`define AGZ_CFG0_MODE_LSB 0
`define AGZ_MUX_TEMP 8'hDE
`define AGZ_MODE_CONT 2'b11
`define AGZ_CFG0_RST 32'h0000_0000
`define AGZ_CFG2_RST 32'h0000_0008
`define AGZ_MUX_RST 32'h0000_0001
`define AGZ_CONV_CYC 16'h0040
`endif

//--- rtl/agz_conv_model.v
// result holder for the first half of a swapped-input pair
`timescale 1ns/1ps
module agz_conv_model (
  input wire clk,
  input wire rst_n,
  input wire wr_en,
  input wire [23:0] wr_data,
  output reg [23:0] rd_data
);
  // read data come from a register so the subtraction sees a stable operand
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 24'h00_0000;
    end else if (wr_en) begin
      rd_data <= wr_data;
    end
  end
endmodule

//--- rtl/agz_ctrl.v
// front-end control: burnout select, temp-diode override, offset cancel sequencing, gain split
// Summary of operation
// R1: burnout select code 0 is off; codes 1..3 pick 0.9, 3.7, 15 uA
// R2: selector 0xDE routes P diode to positive input, M diode to negative
// R3: temp diodes selected (manual or scan) force burnout off, diode bias on
// R4: offset cancel enable resets to 0; writing 1 enables it for later conversions
// R5: offset cancel runs a normal then a swapped-input conversion per result
// R6: offset cancel result is normal minus swapped, divided by two
// R7: offset cancel doubles time per result, single shot included
// R8: offset cancel in continuous mode restarts filter, back-to-back single shots
// R9: gain codes 0..5 are analog only, digital multiplier one
// R10: gain codes 6 and 7 hold analog at 16, digital x2 or x4
// R11: digital gain is a left shift with rounding of filter output (code shifts in zeros and saturates, no rounding)
// R12: selector upper nibble picks positive input, lower nibble negative
// R13: swapped conversion exchanges nibbles internally, software value unchanged
`timescale 1ns/1ps
`include "agz_defs.vh"
module agz_ctrl (
  input wire clk,
  input wire rst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire scan_temp_sel,
  input wire [23:0] filt_data,
  input wire filt_valid,
  output reg [1:0] burnout_sel,
  output reg diode_bias_en,
  output reg [3:0] vin_p_sel,
  output reg [3:0] vin_n_sel,
  output reg [2:0] analog_gain,
  output reg filt_restart,
  output reg conv_start,
  output reg [23:0] result,
  output reg result_valid
);
  localparam ST_IDLE = 2'd0;
  localparam ST_NORM = 2'd1;
  localparam ST_SWAP = 2'd2;

  reg [1:0] cs_sel_r;
  reg [1:0] mode_r;
  reg [2:0] gain_r;
  reg az_en_r;
  reg [7:0] mux_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg busy_r;
  reg single_r;
  reg go_r;
  reg [15:0] cnt_r;
  reg [31:0] conv_count_r;
  reg wr_pend_r;
  reg rd_pend_r;
  reg [7:0] addr_r;
  wire [23:0] held;
  wire temp_sel;
  wire [23:0] shifted;
  wire [24:0] diff;

  // temperature diodes picked manually or by the scan sequencer
  assign temp_sel = (mux_r == `AGZ_MUX_TEMP) || scan_temp_sel; // R2 R3
  assign shifted = shift_round(filt_data, gain_r);
  assign diff = {held[23], held} - {shifted[23], shifted};

  // digital gain: shift left with zero fill, no rounding, saturate
  function [23:0] shift_round;
    input [23:0] d;
    input [2:0] g;
    reg [25:0] w;
    begin
      w = {{2{d[23]}}, d};
      if (g == 3'b110) begin
        w = {w[24:0], 1'b0}; // R10 R11
      end else if (g == 3'b111) begin
        w = {w[23:0], 2'b00}; // R10 R11
      end
      if (w[25:23] != 3'b000 && w[25:23] != 3'b111) begin
        shift_round = w[25] ? 24'h80_0000 : 24'h7F_FFFF;
      end else begin
        shift_round = w[23:0];
      end
    end
  endfunction

  agz_conv_model u_hold (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(state_r == ST_NORM && filt_valid),
    .wr_data(shifted),
    .rd_data(held)
  );

  // bus: one wait-free answer, decode in address phase, act in data phase
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready) begin
        wr_pend_r <= hsel && htrans[1] && hwrite;
        rd_pend_r <= hsel && htrans[1] && !hwrite;
        addr_r <= haddr[7:0];
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_sel_r <= 2'b00;
      mode_r <= 2'b00;
      gain_r <= 3'b001;
      az_en_r <= 1'b0; // R4
      mux_r <= 8'h01;
      go_r <= 1'b0;
      single_r <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      go_r <= 1'b0;
      if (wr_pend_r) begin
        case (addr_r)
          `AGZ_ADDR_CFG0: begin
            cs_sel_r <= hwdata[`AGZ_CFG0_CS_LSB+1:`AGZ_CFG0_CS_LSB]; // R1
            mode_r <= hwdata[`AGZ_CFG0_MODE_LSB+1:`AGZ_CFG0_MODE_LSB];
          end
          `AGZ_ADDR_CFG2: begin
            gain_r <= hwdata[`AGZ_CFG2_GAIN_LSB+2:`AGZ_CFG2_GAIN_LSB];
            az_en_r <= hwdata[`AGZ_CFG2_AZ_BIT]; // R4
          end
          `AGZ_ADDR_MUX: mux_r <= hwdata[7:0];
          `AGZ_ADDR_CTRL: begin
            go_r <= hwdata[0];
            single_r <= hwdata[1];
          end
          default: ;
        endcase
      end
      // read data are registered in the address phase cycle's follow-on
      if (hready && hsel && htrans[1] && !hwrite) begin
        case (haddr[7:0])
          `AGZ_ADDR_CFG0: hrdata <= {28'h000_0000, cs_sel_r, mode_r};
          `AGZ_ADDR_CFG2: hrdata <= {26'h000_0000, gain_r, az_en_r, 2'b00};
          `AGZ_ADDR_MUX: hrdata <= {24'h00_0000, mux_r};
          `AGZ_ADDR_CTRL: hrdata <= {30'h0000_0000, single_r, 1'b0};
          `AGZ_ADDR_STAT: hrdata <= {29'h0000_0000, temp_sel, state_r};
          `AGZ_ADDR_RES: hrdata <= {8'h00, result};
          `AGZ_ADDR_ANA: hrdata <= conv_count_r;
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // a result is one conversion, or a normal+swapped pair under offset cancel
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (go_r || (busy_r && mode_r == `AGZ_MODE_CONT)) state_nxt = ST_NORM;
      ST_NORM: if (filt_valid) state_nxt = az_en_r ? ST_SWAP : ST_IDLE; // R5 R7
      // continuous with offset cancel chains the next pair straight on, no idle cycle between results
      ST_SWAP: if (filt_valid) state_nxt = (busy_r && mode_r == `AGZ_MODE_CONT) ? ST_NORM : ST_IDLE; // R5 R8
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      busy_r <= 1'b0;
      cnt_r <= 16'h0000;
      conv_count_r <= 32'h0000_0000;
      burnout_sel <= 2'b00;
      diode_bias_en <= 1'b0;
      vin_p_sel <= 4'h0;
      vin_n_sel <= 4'h1;
      analog_gain <= 3'b001;
      filt_restart <= 1'b0;
      conv_start <= 1'b0;
      result <= 24'h00_0000;
      result_valid <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (go_r) begin
        busy_r <= !single_r;
      end else if (wr_pend_r && addr_r == `AGZ_ADDR_CTRL && !hwdata[0]) begin
        busy_r <= 1'b0;
      end
      burnout_sel <= temp_sel ? 2'b00 : cs_sel_r; // R1 R3
      diode_bias_en <= temp_sel; // R3
      analog_gain <= gain_r[2:1] == 2'b11 ? 3'b101 : gain_r; // R9 R10
      if (state_nxt == ST_SWAP) begin
        vin_p_sel <= mux_r[3:0]; // R13
        vin_n_sel <= mux_r[7:4]; // R13
      end else begin
        vin_p_sel <= mux_r[7:4]; // R12 R2
        vin_n_sel <= mux_r[3:0]; // R12 R2
      end
      // each half of a pair starts a fresh filter, so continuous mode degrades to single shots
      conv_start <= state_nxt != state_r && state_nxt != ST_IDLE;
      filt_restart <= state_nxt != state_r && state_nxt != ST_IDLE && (az_en_r || state_r == ST_IDLE); // R8
      cnt_r <= state_nxt != state_r ? 16'h0000 : cnt_r + 16'h0001;
      if (conv_start) begin
        conv_count_r <= conv_count_r + 32'h0000_0001;
      end
      result_valid <= 1'b0;
      if (filt_valid && state_r == ST_NORM && !az_en_r) begin
        result <= shifted; // R9
        result_valid <= 1'b1;
      end else if (filt_valid && state_r == ST_SWAP) begin
        result <= diff[24:1]; // R6
        result_valid <= 1'b1; // R7 R8
      end
    end
  end
endmodule

//--- verif/agz_ctrl_properties.sv
// port checker for the front-end control block
`timescale 1ns/1ps
module agz_props (
  input wire clk,
  input wire rst_n,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire scan_temp_sel,
  input wire filt_valid,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire [1:0] burnout_sel,
  input wire diode_bias_en,
  input wire [2:0] analog_gain,
  input wire conv_start,
  input wire result_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_one_start;
    conv_start ##1 !conv_start;
  endsequence
  a_bias_kills_burn: assert property (diode_bias_en |-> burnout_sel == 2'b00) else $error("burnout on");
  a_scan_sets_bias: assert property (scan_temp_sel |=> diode_bias_en) else $error("no diode bias");
  a_bias_holds: assert property (scan_temp_sel [*2] |-> diode_bias_en) else $error("bias dropped");
  a_gain_analog_cap: assert property (analog_gain <= 3'd5) else $error("analog gain over 16");
  a_start_is_pulse: assert property (conv_start |-> s_one_start) else $error("start not a pulse");
  a_result_after_conv: assert property (result_valid |-> $past(filt_valid)) else $error("stray result");
  a_result_is_pulse: assert property (result_valid |=> !result_valid) else $error("result held");
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or error");
  a_rdata_on_read: assert property ($changed(hrdata) |-> $past(hsel && htrans[1] && !hwrite && hready))
    else $error("read data moved");
endmodule
bind agz_ctrl agz_props u_props (.clk(clk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .scan_temp_sel(scan_temp_sel), .filt_valid(filt_valid), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .burnout_sel(burnout_sel), .diode_bias_en(diode_bias_en),
  .analog_gain(analog_gain), .conv_start(conv_start), .result_valid(result_valid));

//--- verif/testbench.sv
// self-checking bench for the front-end control block
`timescale 1ns/1ps
`include "agz_defs.vh"
module testbench;
  reg clk, rst_n, hsel, hwrite, scan_temp_sel, filt_valid;
  reg [31:0] haddr, hwdata, rd, ra, rb;
  reg [1:0] htrans;
  reg [2:0] hsize;
  reg [23:0] filt_data;
  wire [31:0] hrdata;
  wire hready, hresp, diode_bias_en, filt_restart, conv_start, result_valid;
  wire [1:0] burnout_sel;
  wire [3:0] vin_p_sel, vin_n_sel;
  wire [2:0] analog_gain;
  wire [23:0] result;
  integer n_mismatch = 0, checks_done = 0, seed = 32'h2167_2cbe, i, j;
  integer starts = 0, restarts = 0, used = 0;
  agz_ctrl dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .scan_temp_sel(scan_temp_sel), .filt_data(filt_data), .filt_valid(filt_valid), .burnout_sel(burnout_sel),
    .diode_bias_en(diode_bias_en), .vin_p_sel(vin_p_sel), .vin_n_sel(vin_n_sel), .analog_gain(analog_gain),
    .filt_restart(filt_restart), .conv_start(conv_start), .result(result), .result_valid(result_valid));
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input [31:0] s, input [31:0] e, input [8*8:1] nm);
    checks_done = checks_done + 1;
    if (s !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("BAD %0s exp %h got %h", nm, e, s);
    end
  endtask
  // single word transfer; read data is taken at the data-phase edge
  task bus(input w, input [7:0] a, input [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    repeat (2) @(posedge clk);
  endtask
  task run(input [23:0] a, input [23:0] b, input az, input [2:0] g, input [7:0] m, input [1:0] go, input cont);
    integer e;
    if (go != 2'b00)
      bus(1'b1, `AGZ_ADDR_CTRL, {30'h0000_0000, go});
    for (j = 0; j <= az; j = j + 1) begin
      // the start pulse may already have passed while the bus task idled
      while (starts <= used) @(posedge clk);
      used = used + 1;
      chk({vin_p_sel, vin_n_sel}, j ? {m[3:0], m[7:4]} : m, "vin");
      filt_data <= j ? b : a;
      filt_valid <= 1'b1;
      @(posedge clk);
      filt_valid <= 1'b0;
    end
    e = az ? ($signed(a) - $signed(b)) >>> 1 : $signed(a) <<< (g > 5 ? g - 5 : 0);
    if (e > 8388607) e = 8388607;
    if (e < -8388608) e = -8388608;
    do @(posedge clk); while (result_valid !== 1'b1);
    chk({8'h00, result}, {8'h00, e[23:0]}, "result");
    chk(conv_start, cont, "cont");
    chk(restarts, starts, "restart");
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // conversion and filter-restart pulses are counted so no task can miss a one-cycle pulse
  always @(posedge clk) begin
    if (conv_start === 1'b1)
      starts <= starts + 1;
    if (filt_restart === 1'b1)
      restarts <= restarts + 1;
  end
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    conclude;
  end
  initial begin
    {rst_n, hsel, hwrite, scan_temp_sel, filt_valid, htrans, haddr, hwdata, filt_data} = 0;
    hsize = 3'b010;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, `AGZ_ADDR_CFG2, 0);
    chk(rd, `AGZ_CFG2_RST, "cfg2");
    bus(1'b0, `AGZ_ADDR_MUX, 0);
    chk(rd, `AGZ_MUX_RST, "mux");
    bus(1'b0, 8'h40, 0);
    chk(rd, 0, "unmapped");
    for (i = 0; i < 4; i = i + 1) begin
      bus(1'b1, `AGZ_ADDR_CFG0, i << 2);
      chk(burnout_sel, i, "burnout");
    end
    bus(1'b1, `AGZ_ADDR_MUX, `AGZ_MUX_TEMP);
    chk({diode_bias_en, burnout_sel}, 3'b100, "temp");
    chk({vin_p_sel, vin_n_sel}, `AGZ_MUX_TEMP, "vin");
    bus(1'b0, `AGZ_ADDR_CFG0, 0);
    chk(rd, 32'h0000_000C, "cfg0");
    scan_temp_sel <= 1'b1;
    bus(1'b1, `AGZ_ADDR_MUX, 8'h10);
    chk({diode_bias_en, burnout_sel}, 3'b100, "scan");
    scan_temp_sel <= 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      bus(1'b1, `AGZ_ADDR_CFG2, i << 3);
      chk(analog_gain, i > 5 ? 5 : i, "gain");
      ra = $random(seed);
      run(ra[23:0], 24'h00_0000, 1'b0, i[2:0], 8'h10, 2'b11, 1'b0);
    end
    bus(1'b1, `AGZ_ADDR_CFG2, 32'h0000_000C);
    for (i = 0; i < 4; i = i + 1) begin
      ra = $random(seed);
      rb = $random(seed);
      run(ra[23:0], rb[23:0], 1'b1, 3'd1, 8'h10, 2'b11, 1'b0);
    end
    // continuous mode with offset cancel: pairs follow each other with no gap
    bus(1'b1, `AGZ_ADDR_CFG0, 32'h0000_0003);
    for (i = 0; i < 2; i = i + 1) begin
      ra = $random(seed);
      rb = $random(seed);
      run(ra[23:0], rb[23:0], 1'b1, 3'd1, 8'h10, i == 0 ? 2'b01 : 2'b00, 1'b1);
    end
    conclude;
  end
endmodule
